// ===== core/mlc_coordinator.sv
// multi-axis lag coordinator top with ahb-lite register slave
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "mlc_defines.svh"
module mlc_coordinator
  import mlc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic sys_rst, // sync reset, high
  input wire logic ce, // clock enable
  input wire logic hsel, // ahb select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb ready in
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb ready out
  output logic hresp, // ahb response
  input wire logic enable_system, // system enable
  input wire logic sync_request, // request synchronous operation
  input wire logic start_sync, // move trigger, rising edge
  input wire logic [`MLC_NAXES-1:0] single_axis_mode_request, // per-axis local request
  input wire logic [`MLC_NAXES-1:0] local_enable, // per-axis local enable
  input wire logic [`MLC_NAXES-1:0] axis_local_fb, // axis reports local mode
  input wire logic [`MLC_NAXES-1:0] axis_ready, // axis ready
  input wire logic [`MLC_NAXES*`MLC_POS_W-1:0] axis_pos, // actual positions
  input wire logic [`MLC_NAXES*`MLC_POS_W-1:0] axis_lag, // control deviations
  input wire logic data_fault, // data fault
  input wire logic bus_fault, // bus fault
  input wire logic rx_drv_fault, // receive driver fault
  input wire logic tx_drv_fault, // transmit driver fault
  input wire logic live_fault, // live-bit fault
  output logic [`MLC_NAXES-1:0] axis_enable, // enable to each axis
  output logic [`MLC_NAXES-1:0] axis_local_grant, // local mode allowed
  output logic axis_start, // one-cycle move start to all axes
  output logic profile_halt, // halt all profile generators
  output logic [`MLC_POS_W-1:0] target_position, // latched target
  output logic [`MLC_SPD_W-1:0] move_speed, // latched speed
  output logic [`MLC_POS_W-1:0] lowest_axis_position, // min position
  output logic [`MLC_POS_W-1:0] highest_axis_position, // max position
  output logic [`MLC_POS_W-1:0] lag_spread, // lag spread
  output logic [`MLC_FAULT_W-1:0] fault_word, // bit-coded faults
  output logic system_ready, // all axes ready
  output logic sync_active, // synchronous mode in effect
  output logic [`MLC_STATE_W-1:0] state_code // state machine diagnostic
);
  typedef struct packed {
    logic [31:0] lag_stop_limit;
    logic [31:0] lag_stop_hysteresis;
    logic [31:0] tgt_pre;
    logic [`MLC_SPD_W-1:0] spd_pre;
    logic [`MLC_POS_W-1:0] tgt;
    logic [`MLC_SPD_W-1:0] spd;
    logic trig_prev;
    logic start;
    logic halt;
    logic [`MLC_NAXES-1:0] en;
    logic [`MLC_NAXES-1:0] grant;
    logic [`MLC_FAULT_W-1:0] fault;
    logic rdy;
    logic sact;
    mlc_state_t state;
    logic dph;
    logic dwr;
    logic [31:0] daddr;
    logic [31:0] rdata;
  } mlc_state_reg_t;
  mlc_state_reg_t s_reg, s_next;
  logic [`MLC_POS_W-1:0] st_min, st_max, st_spread, st_abs;

  mlc_axis_stats u_stats (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pos_in(axis_pos),
    .lag_in(axis_lag),
    .pos_min(st_min),
    .pos_max(st_max),
    .spread(st_spread),
    .abs_max(st_abs)
  );

  logic any_local, sync_ok, trig_rise, addr_ok;
  logic [32:0] thr_hi, thr_lo;
  assign any_local = |axis_local_fb;
  // any axis in local mode blocks sync
  assign sync_ok = sync_request & enable_system & ~any_local;
  assign trig_rise = start_sync & ~s_reg.trig_prev;
  assign thr_hi = {1'b0, s_reg.lag_stop_limit} + {1'b0, s_reg.lag_stop_hysteresis};
  // floor at zero so a large hysteresis never wraps the lower threshold
  assign thr_lo = (s_reg.lag_stop_limit > s_reg.lag_stop_hysteresis) ?
                  {1'b0, s_reg.lag_stop_limit - s_reg.lag_stop_hysteresis} : 33'h0_0000_0000;
  assign addr_ok = hsel & hready & htrans[1];

  always_comb begin
    s_next = s_reg;
    s_next.trig_prev = start_sync;
    s_next.start = 1'b0;
    // ahb-lite: zero wait states, always okay
    s_next.dph = addr_ok;
    s_next.dwr = addr_ok & hwrite;
    if (addr_ok) begin
      s_next.daddr = haddr;
    end
    if (s_reg.dph && s_reg.dwr) begin
      case (s_reg.daddr)
        `MLC_OFF_STOP: s_next.lag_stop_limit = hwdata;
        `MLC_OFF_HYST: s_next.lag_stop_hysteresis = hwdata;
        `MLC_OFF_TGT: s_next.tgt_pre = hwdata;
        `MLC_OFF_SPD: s_next.spd_pre = hwdata[`MLC_SPD_W-1:0];
        default: ;
      endcase
    end
    // hysteresis comparator, holds between thresholds
    if ({1'b0, st_abs} > thr_hi) begin
      s_next.halt = 1'b1;
    end else if ({1'b0, st_abs} < thr_lo) begin
      s_next.halt = 1'b0;
    end
    // one halt line feeds every axis, so all stop together
    if (!sync_ok) begin
      s_next.halt = 1'b0;
    end
    s_next.fault = '0;
    s_next.fault[`MLC_FB_DATA] = data_fault;
    s_next.fault[`MLC_FB_BUS] = bus_fault;
    s_next.fault[`MLC_FB_RXDRV] = rx_drv_fault;
    s_next.fault[`MLC_FB_TXDRV] = tx_drv_fault;
    s_next.fault[`MLC_FB_LIVE] = live_fault;
    s_next.rdy = &axis_ready;
    s_next.grant = sync_request ? '0 : single_axis_mode_request;
    for (int i = 0; i < `MLC_NAXES; i++) begin
      s_next.en[i] = axis_local_fb[i] ? local_enable[i] : enable_system;
    end
    if (trig_rise && sync_ok) begin
      s_next.tgt = s_reg.tgt_pre;
      s_next.spd = s_reg.spd_pre;
      s_next.start = 1'b1;
    end
    case (s_reg.state)
      MLC_ST_OFF: begin
        if (any_local) s_next.state = MLC_ST_LOCAL;
        else if (sync_ok) s_next.state = MLC_ST_IDLE;
      end
      MLC_ST_LOCAL: begin
        if (!any_local) s_next.state = MLC_ST_OFF;
      end
      MLC_ST_IDLE: begin
        if (!sync_ok) s_next.state = any_local ? MLC_ST_LOCAL : MLC_ST_OFF;
        else if (trig_rise) s_next.state = MLC_ST_MOVING;
      end
      MLC_ST_MOVING, MLC_ST_HALTED: begin
        if (!sync_ok) s_next.state = any_local ? MLC_ST_LOCAL : MLC_ST_OFF;
        else s_next.state = s_next.halt ? MLC_ST_HALTED : MLC_ST_MOVING;
      end
      default: s_next.state = MLC_ST_OFF;
    endcase
    s_next.sact = sync_ok;
    // limits read through the write path, so a read right behind a write sees it
    case (haddr)
      `MLC_OFF_CTRL: s_next.rdata = {29'h0, sync_ok, any_local, enable_system};
      `MLC_OFF_STOP: s_next.rdata = s_next.lag_stop_limit;
      `MLC_OFF_HYST: s_next.rdata = s_next.lag_stop_hysteresis;
      `MLC_OFF_TGT: s_next.rdata = s_reg.tgt;
      `MLC_OFF_SPD: s_next.rdata = {16'h0, s_reg.spd};
      `MLC_OFF_STAT: s_next.rdata = {29'h0, s_reg.halt, s_reg.sact, s_reg.rdy};
      `MLC_OFF_FAULT: s_next.rdata = {24'h0, s_reg.fault};
      `MLC_OFF_LOWEST_AXIS_POSITION: s_next.rdata = st_min;
      `MLC_OFF_HIGHEST_AXIS_POSITION: s_next.rdata = st_max;
      `MLC_OFF_SPREAD: s_next.rdata = st_spread;
      `MLC_OFF_STATE: s_next.rdata = {29'h0, s_reg.state};
      default: s_next.rdata = 32'h0000_0000;
    endcase
    if (!addr_ok || hwrite) begin
      s_next.rdata = s_reg.rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.lag_stop_limit <= `MLC_STOP_RST;
      s_reg.lag_stop_hysteresis <= `MLC_HYST_RST;
      s_reg.state <= MLC_ST_OFF;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign hrdata = s_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign axis_enable = s_reg.en;
  assign axis_local_grant = s_reg.grant;
  assign axis_start = s_reg.start;
  assign profile_halt = s_reg.halt;
  assign target_position = s_reg.tgt;
  assign move_speed = s_reg.spd;
  assign lowest_axis_position = st_min;
  assign highest_axis_position = st_max;
  assign lag_spread = st_spread;
  assign fault_word = s_reg.fault;
  assign system_ready = s_reg.rdy;
  assign sync_active = s_reg.sact;
  assign state_code = {5'h00, s_reg.state};

  chk_fault_clear: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !(data_fault | bus_fault | rx_drv_fault | tx_drv_fault | live_fault)
    |=> fault_word == 8'h00)
    else $error("fault word not zero without faults");
  chk_fault_sum: assert property (@(posedge clk) disable iff (sys_rst)
    ce |=> fault_word == ({7'h0, $past(data_fault)} + 8'h04 * $past(bus_fault)
      + 8'h08 * $past(rx_drv_fault) + 8'h10 * $past(tx_drv_fault)
      + 8'h20 * $past(live_fault)))
    else $error("fault word not the sum of weights");
  chk_local_block: assert property (@(posedge clk) disable iff (sys_rst)
    ce && sync_request |=> axis_local_grant == '0)
    else $error("local mode granted under sync request");
  chk_start_edge: assert property (@(posedge clk) disable iff (sys_rst)
    ce && $past(ce) && start_sync && $past(start_sync) |=> !axis_start)
    else $error("move started by steady trigger");
  chk_target_hold: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !axis_start ##1 ce && !axis_start |-> $stable(target_position))
    else $error("target changed without a start");
  chk_halt_set: assert property (@(posedge clk) disable iff (sys_rst)
    ce && sync_ok && ({1'b0, st_abs} > thr_hi) |=> profile_halt)
    else $error("halt not set above upper threshold");
  chk_halt_clear: assert property (@(posedge clk) disable iff (sys_rst)
    ce && ({1'b0, st_abs} < thr_lo) |=> !profile_halt)
    else $error("halt not cleared below lower threshold");
  chk_ready_all: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !(&axis_ready) |=> !system_ready)
    else $error("ready with an axis not ready");
  chk_sync_block: assert property (@(posedge clk) disable iff (sys_rst)
    ce && any_local |=> !sync_active ##0 !axis_start)
    else $error("sync active while an axis is local");
  chk_enable_fwd: assert property (@(posedge clk) disable iff (sys_rst)
    ce && axis_local_fb == '0 |=> axis_enable == {`MLC_NAXES{$past(enable_system)}})
    else $error("system enable not forwarded");
  // mode, sequencing and halt properties that the scalar checks above leave open
  chk_sync_flag: assert property (@(posedge clk) disable iff (sys_rst)
    ce
    |=> sync_active == $past(sync_ok))
    else $error("sync flag not following sync conditions");
  chk_state_off: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !sync_ok
    |=> state_code == 8'h00 || state_code == 8'h01)
    else $error("state not off or local without sync");
  chk_state_halt: assert property (@(posedge clk) disable iff (sys_rst)
    ce && sync_ok && (state_code == 8'h03 || state_code == 8'h04)
    |=> state_code == (profile_halt ? 8'h04 : 8'h03))
    else $error("run state does not match the halt flag");
  chk_local_state: assert property (@(posedge clk) disable iff (sys_rst)
    ce && any_local
    |=> state_code == 8'h01)
    else $error("state not local while an axis is local");
  chk_halt_sync: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !sync_ok
    |=> !profile_halt)
    else $error("halt raised outside synchronous operation");
  chk_halt_hold: assert property (@(posedge clk) disable iff (sys_rst)
    ce && sync_ok && ({1'b0, st_abs} <= thr_hi) && ({1'b0, st_abs} >= thr_lo)
    |=> profile_halt == $past(profile_halt))
    else $error("halt changed between the thresholds");
  chk_start_rise: assert property (@(posedge clk) disable iff (sys_rst)
    ce && $past(ce) && sync_ok && start_sync && !$past(start_sync)
    |=> axis_start)
    else $error("trigger edge did not start a move");
  chk_start_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    ce && axis_start
    |=> !axis_start)
    else $error("move start longer than one cycle");
  chk_target_load: assert property (@(posedge clk) disable iff (sys_rst)
    ce && sync_ok && trig_rise
    |=> target_position == $past(s_reg.tgt_pre)
      && move_speed == $past(s_reg.spd_pre))
    else $error("presets not taken at the trigger edge");
  chk_speed_hold: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !axis_start ##1 ce && !axis_start
    |-> $stable(move_speed))
    else $error("speed changed without a start");
  chk_ready_set: assert property (@(posedge clk) disable iff (sys_rst)
    ce && (&axis_ready)
    |=> system_ready)
    else $error("not ready with every axis ready");
  chk_grant_free: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !sync_request
    |=> axis_local_grant == $past(single_axis_mode_request))
    else $error("local request not passed without sync request");
  chk_fault_bits: assert property (@(posedge clk) disable iff (sys_rst)
    ce
    |=> fault_word[1] == 1'b0 && fault_word[7:6] == 2'b00)
    else $error("unused fault bit set");
  chk_spread_zero: assert property (@(posedge clk) disable iff (sys_rst)
    ce && (axis_lag == {`MLC_NAXES{axis_lag[`MLC_POS_W-1:0]}})
    |=> lag_spread == '0)
    else $error("spread not zero for equal lags");

  // per-axis bounds on the reported extremes and on the enable path
  for (genvar g = 0; g < `MLC_NAXES; g++) begin : g_axis_chk
    logic signed [`MLC_POS_W-1:0] pos_g;
    assign pos_g = axis_pos[g*`MLC_POS_W +: `MLC_POS_W];
    chk_low_bound: assert property (@(posedge clk) disable iff (sys_rst)
      ce
      |=> $signed(lowest_axis_position) <= $past(pos_g))
      else $error("lowest position above an axis position");
    chk_high_bound: assert property (@(posedge clk) disable iff (sys_rst)
      ce
      |=> $signed(highest_axis_position) >= $past(pos_g))
      else $error("highest position below an axis position");
    chk_local_path: assert property (@(posedge clk) disable iff (sys_rst)
      ce && axis_local_fb[g]
      |=> axis_enable[g] == $past(local_enable[g]))
      else $error("local axis not given its own enable");
    chk_system_path: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !axis_local_fb[g]
      |=> axis_enable[g] == $past(enable_system))
      else $error("synchronous axis not given the system enable");
  end
endmodule // mlc_coordinator
`default_nettype wire

// ===== pkg/mlc_defines.svh
// constants for the multi-axis lag coordinator
`ifndef MLC_DEFINES_SVH
`define MLC_DEFINES_SVH
`define MLC_NAXES 4
`define MLC_POS_W 32
`define MLC_SPD_W 16
`define MLC_FAULT_W 8
`define MLC_FB_DATA 0
`define MLC_FB_BUS 2
`define MLC_FB_RXDRV 3
`define MLC_FB_TXDRV 4
`define MLC_FB_LIVE 5
`define MLC_STATE_W 8
`define MLC_OFF_CTRL 32'h0000_0000
`define MLC_OFF_STOP 32'h0000_0004
`define MLC_OFF_HYST 32'h0000_0008
`define MLC_OFF_TGT 32'h0000_000c
`define MLC_OFF_SPD 32'h0000_0010
`define MLC_OFF_STAT 32'h0000_0014
`define MLC_OFF_FAULT 32'h0000_0018
`define MLC_OFF_LOWEST_AXIS_POSITION 32'h0000_001c
`define MLC_OFF_HIGHEST_AXIS_POSITION 32'h0000_0020
`define MLC_OFF_SPREAD 32'h0000_0024
`define MLC_OFF_STATE 32'h0000_0028
`define MLC_STOP_RST 32'h0000_0000
`define MLC_HYST_RST 32'h0000_0000
`endif

// ===== pkg/mlc_pkg.sv
// types for the multi-axis lag coordinator
package mlc_pkg;
  typedef enum logic [2:0] {
    MLC_ST_OFF,
    MLC_ST_LOCAL,
    MLC_ST_IDLE,
    MLC_ST_MOVING,
    MLC_ST_HALTED
  } mlc_state_t;
endpackage

// ===== core/mlc_axis_stats.sv
// min/max position and lag spread over all axes, registered
`timescale 1ns/10ps
`default_nettype none
`include "mlc_defines.svh"
module mlc_axis_stats
  import mlc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic sys_rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic [`MLC_NAXES*`MLC_POS_W-1:0] pos_in, // actual positions
  input wire logic [`MLC_NAXES*`MLC_POS_W-1:0] lag_in, // signed lags
  output logic [`MLC_POS_W-1:0] pos_min, // lowest position
  output logic [`MLC_POS_W-1:0] pos_max, // highest position
  output logic [`MLC_POS_W-1:0] spread, // max lag minus min lag
  output logic [`MLC_POS_W-1:0] abs_max // largest abs lag
);
  typedef struct packed {
    logic [`MLC_POS_W-1:0] mn;
    logic [`MLC_POS_W-1:0] mx;
    logic [`MLC_POS_W-1:0] sp;
    logic [`MLC_POS_W-1:0] am;
  } mlc_stats_t;
  mlc_stats_t st_reg, st_next;
  logic signed [`MLC_POS_W-1:0] p [`MLC_NAXES];
  logic signed [`MLC_POS_W-1:0] l [`MLC_NAXES];
  logic [`MLC_POS_W-1:0] a [`MLC_NAXES];
  genvar g;
  generate
    for (g = 0; g < `MLC_NAXES; g++) begin : g_ax
      assign p[g] = pos_in[g*`MLC_POS_W +: `MLC_POS_W];
      assign l[g] = lag_in[g*`MLC_POS_W +: `MLC_POS_W];
      assign a[g] = l[g][`MLC_POS_W-1] ? -l[g] : l[g];
    end
  endgenerate
  always_comb begin
    logic signed [`MLC_POS_W-1:0] pmn, pmx, lmn, lmx;
    logic [`MLC_POS_W-1:0] amx;
    pmn = p[0];
    pmx = p[0];
    lmn = l[0];
    lmx = l[0];
    amx = a[0];
    for (int i = 1; i < `MLC_NAXES; i++) begin
      if (p[i] < pmn) pmn = p[i];
      if (p[i] > pmx) pmx = p[i];
      if (l[i] < lmn) lmn = l[i];
      if (l[i] > lmx) lmx = l[i];
      if (a[i] > amx) amx = a[i];
    end
    st_next.mn = pmn;
    st_next.mx = pmx;
    st_next.sp = lmx - lmn;
    st_next.am = amx;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
  assign pos_min = st_reg.mn;
  assign pos_max = st_reg.mx;
  assign spread = st_reg.sp;
  assign abs_max = st_reg.am;
endmodule // mlc_axis_stats
`default_nettype wire

// ===== verif/mlc_axis_model.sv
// behavioural model of the four hydraulic axis modules on the fieldbus
`timescale 1ns/10ps
`default_nettype none
`include "mlc_defines.svh"
module mlc_axis_model (
  input wire logic clk, // clock
  input wire logic [`MLC_NAXES-1:0] axis_enable, // enable from coordinator
  input wire logic [`MLC_NAXES-1:0] axis_local_grant, // local mode allowed
  input wire logic [`MLC_NAXES-1:0] ready_mask, // bench: axes able to be ready
  input wire logic [`MLC_NAXES*`MLC_POS_W-1:0] pos_cmd, // bench: positions
  input wire logic [`MLC_NAXES*`MLC_POS_W-1:0] lag_cmd, // bench: lags
  output logic [`MLC_NAXES-1:0] axis_local_fb, // local mode reached
  output logic [`MLC_NAXES-1:0] axis_ready, // axis ready
  output logic [`MLC_NAXES*`MLC_POS_W-1:0] axis_pos, // actual positions
  output logic [`MLC_NAXES*`MLC_POS_W-1:0] axis_lag // control deviations
);
  // one cycle of transport, as the fieldbus delays every report
  always_ff @(posedge clk) begin
    axis_local_fb <= axis_local_grant;
    // a disabled axis never reports readiness
    axis_ready <= ready_mask & axis_enable;
    axis_pos <= pos_cmd;
    axis_lag <= lag_cmd;
  end
endmodule // mlc_axis_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking testbench of the multi-axis lag coordinator
`timescale 1ns/10ps
`default_nettype none
`include "mlc_defines.svh"
module tb;
  import mlc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic enable_system = 1'b0, sync_request = 1'b0, start_sync = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] single_axis_mode_request = 4'h0, local_enable = 4'h0, ready_mask = 4'h0;
  logic [4:0] flt = 5'h0;
  logic [127:0] pos_cmd = 128'h0, lag_cmd = 128'h0, axis_pos, axis_lag;
  logic hready, hreadyout, hresp, axis_start, profile_halt, system_ready, sync_active;
  logic [31:0] hrdata, target_position, lowest_axis_position, highest_axis_position, lag_spread;
  logic [3:0] axis_enable, axis_local_grant, axis_local_fb, axis_ready;
  logic [15:0] move_speed;
  logic [7:0] fault_word, state_code;
  logic [7:0] wt [5] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20};
  logic [31:0] lv [7] = '{32'h6e, 32'h6f, 32'h5a, 32'h59, 32'h69, 32'hffff_ff91, 32'h0};
  logic [6:0] hv = 7'h26;
  int n_fail = 0, check_count = 0;

  always #5 clk = ~clk;
  assign hready = hreadyout;

  mlc_coordinator i_dut (.clk, .sys_rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .enable_system, .sync_request, .start_sync,
    .single_axis_mode_request, .local_enable, .axis_local_fb, .axis_ready, .axis_pos,
    .axis_lag, .data_fault(flt[0]), .bus_fault(flt[1]), .rx_drv_fault(flt[2]),
    .tx_drv_fault(flt[3]), .live_fault(flt[4]), .axis_enable, .axis_local_grant, .axis_start,
    .profile_halt, .target_position, .move_speed, .lowest_axis_position,
    .highest_axis_position, .lag_spread, .fault_word, .system_ready, .sync_active,
    .state_code);
  mlc_axis_model i_axes (.clk, .axis_enable, .axis_local_grant, .ready_mask, .pos_cmd,
    .lag_cmd, .axis_local_fb, .axis_ready, .axis_pos, .axis_lag);

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // single ahb transfer; waits are bounded so a stuck slave ends the run
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  // raise the trigger, hold it high, count the start pulses seen
  task automatic trig(input int exp);
    int n;
    n = 0;
    start_sync <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      if (axis_start === 1'b1) n++;
    end
    start_sync <= 1'b0;
    cyc(1);
    chk(n, exp);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    cyc(10);
    sys_rst <= 1'b0;
    cyc(1);
    rdc(`MLC_OFF_STOP, `MLC_STOP_RST);
    rdc(`MLC_OFF_HYST, `MLC_HYST_RST);
    rdc(32'h0000_0040, 32'h0);
    wr(`MLC_OFF_FAULT, 32'hffff_ffff);
    rdc(`MLC_OFF_FAULT, 32'h0);
    done("registers");
    for (int i = 0; i < 5; i++) begin
      flt <= 5'h1 << i;
      cyc(3);
      chk(fault_word, wt[i]);
    end
    flt <= 5'h1f;
    cyc(3);
    chk(fault_word, 8'h3d);
    rdc(`MLC_OFF_FAULT, 32'h3d);
    flt <= 5'h0;
    cyc(3);
    chk(fault_word, 8'h0);
    done("faults");
    enable_system <= 1'b1;
    sync_request <= 1'b1;
    single_axis_mode_request <= 4'hf;
    local_enable <= 4'h5;
    cyc(4);
    chk(axis_enable, 4'hf);
    chk(axis_local_grant, 4'h0);
    chk(sync_active, 1'b1);
    chk(state_code, 8'h2);
    enable_system <= 1'b0;
    cyc(4);
    chk(axis_enable, 4'h0);
    chk(sync_active, 1'b0);
    sync_request <= 1'b0;
    enable_system <= 1'b1;
    cyc(4);
    chk(axis_local_grant, 4'hf);
    chk(axis_enable, 4'h5);
    chk(state_code, 8'h1);
    // axes in local mode must refuse a coordinated start
    sync_request <= 1'b1;
    single_axis_mode_request <= 4'h0;
    cyc(1);
    trig(0);
    cyc(4);
    done("modes");
    wr(`MLC_OFF_TGT, 32'h1234);
    wr(`MLC_OFF_SPD, 32'h55);
    trig(1);
    chk(target_position, 32'h1234);
    chk(move_speed, 16'h55);
    wr(`MLC_OFF_TGT, 32'habcd);
    cyc(2);
    chk(target_position, 32'h1234);
    trig(1);
    chk(target_position, 32'habcd);
    done("move");
    pos_cmd <= {32'h50, 32'hffff_fff0, 32'h100, 32'h7};
    lag_cmd <= {32'h3, 32'hffff_fffb, 32'h9, 32'h1};
    ready_mask <= 4'hf;
    cyc(4);
    chk(lowest_axis_position, 32'hffff_fff0);
    chk(highest_axis_position, 32'h100);
    chk(lag_spread, 32'he);
    chk(system_ready, 1'b1);
    ready_mask <= 4'hb;
    cyc(4);
    chk(system_ready, 1'b0);
    done("stats");
    // limit above normal lags, hysteresis wide enough to stop flutter
    wr(`MLC_OFF_STOP, 32'h64);
    wr(`MLC_OFF_HYST, 32'ha);
    for (int i = 0; i < 7; i++) begin
      lag_cmd <= {32'h0, lv[i], 64'h0};
      cyc(5);
      chk(profile_halt, hv[i]);
      chk(state_code, hv[i] ? 8'h4 : 8'h3);
    end
    lag_cmd <= {32'h0, lv[1], 64'h0};
    cyc(5);
    chk(profile_halt, 1'b1);
    sys_rst <= 1'b1;
    cyc(1);
    sys_rst <= 1'b0;
    cyc(1);
    chk(profile_halt, 1'b0);
    done("halt");
    close_out();
  end
endmodule // tb
`default_nettype wire
